/* src/lpm_consts.svh */
// Offsets, codes, reset values and timing counts for the mode/activate block
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// Mode register addresses
`define LPM_MA_DEVICE_INFO 8'h08
`define LPM_MA_VENDOR_TEST 8'h09
`define LPM_MA_CALIBRATION 8'h0A
`define LPM_MA_RSVD_A_LO 8'h0B
`define LPM_MA_RSVD_A_HI 8'h0F
`define LPM_MA_BANK_MASK 8'h10
`define LPM_MA_SEG_MASK 8'h11
`define LPM_MA_RESET 8'h3F

// Device information fields
`define LPM_INFO_TYPE 2'h0
`define LPM_INFO_DENSITY 4'h4
`define LPM_INFO_WIDTH 2'h1

// Calibration codes
`define LPM_CAL_INIT 8'hFF
`define LPM_CAL_LONG 8'hAB
`define LPM_CAL_SHORT 8'h56
`define LPM_CAL_RESET 8'hC3

// Reset values
`define LPM_BANK_MASK_RST 8'h00
`define LPM_SEG_MASK_RST 8'h00

// Command address field positions
`define LPM_CA_ALLBANK_BIT 4
`define LPM_CA_READ_BIT 2

// Activate-to-column delay
`define LPM_CLK_PS 8000
`define LPM_TRCD_NS 18
`define LPM_TRCD_CYC \
  ((`LPM_TRCD_NS * 1000 + `LPM_CLK_PS - 1) / `LPM_CLK_PS)
`define LPM_RCD_W 4

`endif

/* src/lpm_pkg.sv */
// Types shared by the mode register and activate logic
package lpm_pkg;

  typedef struct packed {
    logic cs_b;
    logic [9:0] rise;
    logic [9:0] fall;
  } lpm_ca_t;

  typedef enum logic [2:0] {
    LPM_CMD_NOP,
    LPM_CMD_ACT,
    LPM_CMD_RDWR,
    LPM_CMD_PRE,
    LPM_CMD_MRW,
    LPM_CMD_MRR,
    LPM_CMD_OTHER
  } lpm_cmd_t;

  typedef struct packed {
    logic [2:0] bank;
    logic [12:0] row;
  } lpm_act_t;

endpackage

/* src/lpm_mode_act.sv */
// Upper mode register map and row activate tracking of the memory device
// Notes on behaviour
// - Register 08H reads fixed type, density, width.
// - Register 09H is vendor test, no function.
// - Writes to 0AH start listed calibration actions.
// - Reserved calibration codes are ignored entirely.
// - Reference pin tied high ignores calibration.
// - Registers 0BH to 0FH are reserved.
// - 10H bank mask; one blocks refresh.
// - 11H segment mask by row bits 12:10.
// - Write to 3FH resets device; write-only.
// - Select low, CA0 low, CA1 high is activate.
// - Activate opens given row in given bank.
// - Column access accepted after activate delay.
`include "lpm_consts.svh"

module lpm_mode_act #(
  parameter int NUM_BANKS = 8,
  parameter int ROW_W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command and address from the controller
  input wire lpm_pkg::lpm_ca_t ca_in,
  // Strap: calibration reference pin tied to core supply
  input wire logic calib_ref_tied,
  // Mode register read return
  output logic mrr_valid,
  output logic [7:0] mrr_data,
  // Calibration request
  output logic calib_start,
  output logic [7:0] calib_code,
  // Partial array refresh masks
  output logic [7:0] refresh_bank_mask,
  output logic [7:0] refresh_segment_mask,
  // Device reset request
  output logic device_reset,
  // Activate report
  output logic act_valid,
  output lpm_pkg::lpm_act_t act_info,
  output logic [NUM_BANKS-1:0] bank_open,
  // Column access report
  output logic rdwr_accept,
  output logic rdwr_reject,
  output logic rdwr_is_read,
  output logic [2:0] rdwr_bank,
  // Command not serviceable in the current bank state
  output logic cmd_error
);
  import lpm_pkg::*;

  generate
    if (NUM_BANKS != 8 || ROW_W != 13) begin : g_bad_cfg
      $error("lpm_mode_act supports 8 banks and 13 row bits only");
    end
  endgenerate

  localparam int RCD_CYC_I = `LPM_TRCD_CYC;
  localparam int RCD_ONE_I = 1;
  localparam logic [`LPM_RCD_W-1:0] RCD_CYC = RCD_CYC_I[`LPM_RCD_W-1:0];
  localparam logic [`LPM_RCD_W-1:0] RCD_ONE = RCD_ONE_I[`LPM_RCD_W-1:0];

  // Two stages before decode: the bus arrives from the pins
  lpm_ca_t ca_s1;
  lpm_ca_t ca_s2;
  logic tied_s1;
  logic tied_s2;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ca_s1 <= '{cs_b: 1'b1, rise: 10'h000, fall: 10'h000};
      ca_s2 <= '{cs_b: 1'b1, rise: 10'h000, fall: 10'h000};
      tied_s1 <= 1'b0;
      tied_s2 <= 1'b0;
    end else begin
      ca_s1 <= ca_in;
      ca_s2 <= ca_s1;
      tied_s1 <= calib_ref_tied;
      tied_s2 <= tied_s1;
    end
  end

  // Command decode
  wire sel = ~ca_s2.cs_b;
  wire [9:0] cr = ca_s2.rise;
  wire [9:0] cf = ca_s2.fall;
  lpm_cmd_t cmd;

  always_comb begin
    if (!sel) begin
      cmd = LPM_CMD_NOP;
    end else if (!cr[0] && cr[1]) begin
      cmd = LPM_CMD_ACT;
    end else if (cr[0] && !cr[1]) begin
      cmd = LPM_CMD_RDWR;
    end else if (cr[3:0] == 4'h0) begin
      cmd = LPM_CMD_MRW;
    end else if (cr[3:0] == 4'h8) begin
      cmd = LPM_CMD_MRR;
    end else if (cr[3:0] == 4'hB) begin
      cmd = LPM_CMD_PRE;
    end else begin
      cmd = LPM_CMD_OTHER;
    end
  end

  wire [7:0] ma = {cf[1:0], cr[9:4]};
  wire [7:0] op = cf[9:2];
  wire [2:0] cmd_bank = cr[9:7];
  wire [ROW_W-1:0] cmd_row = {cr[6:2], cf[9:2]};
  wire pre_all = cr[`LPM_CA_ALLBANK_BIT];

  wire is_mrw = (cmd == LPM_CMD_MRW);
  wire is_mrr = (cmd == LPM_CMD_MRR);
  wire is_act = (cmd == LPM_CMD_ACT);
  wire is_rdwr = (cmd == LPM_CMD_RDWR);
  wire is_pre = (cmd == LPM_CMD_PRE);

  // Mode register writes
  wire wr_bank_mask = is_mrw && (ma == `LPM_MA_BANK_MASK);
  wire wr_seg_mask = is_mrw && (ma == `LPM_MA_SEG_MASK);
  wire wr_reset = is_mrw && (ma == `LPM_MA_RESET);
  wire wr_calib = is_mrw && (ma == `LPM_MA_CALIBRATION);

  wire code_known = (op == `LPM_CAL_INIT) || (op == `LPM_CAL_LONG) ||
    (op == `LPM_CAL_SHORT) || (op == `LPM_CAL_RESET);
  // Reserved codes and a tied reference pin both drop the command
  wire next_calib_start = wr_calib && code_known && !tied_s2;

  // Mode register reads; every address but 08H gives 0, and write-only 3FH gives no response
  wire [7:0] info_value =
    {`LPM_INFO_WIDTH, `LPM_INFO_DENSITY, `LPM_INFO_TYPE};
  wire [7:0] next_mrr_data =
    (ma == `LPM_MA_DEVICE_INFO) ? info_value : 8'h00;
  // Reset register has no read path
  wire next_mrr_valid = is_mrr && (ma != `LPM_MA_RESET);

  // Soft reset raised by the reset register write, applied next cycle
  logic soft_rst;
  wire clr = !rst_b || soft_rst;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      soft_rst <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      soft_rst <= wr_reset;
      device_reset <= wr_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      refresh_bank_mask <= `LPM_BANK_MASK_RST;
      refresh_segment_mask <= `LPM_SEG_MASK_RST;
    end else begin
      if (wr_bank_mask) begin
        refresh_bank_mask <= op;
      end
      if (wr_seg_mask) begin
        refresh_segment_mask <= op;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      calib_start <= 1'b0;
      calib_code <= 8'h00;
      mrr_valid <= 1'b0;
      mrr_data <= 8'h00;
    end else begin
      calib_start <= next_calib_start;
      if (next_calib_start) begin
        calib_code <= op;
      end
      mrr_valid <= next_mrr_valid;
      mrr_data <= next_mrr_valid ? next_mrr_data : 8'h00;
    end
  end

  // Per-bank open state and activate-to-column countdown
  logic [`LPM_RCD_W-1:0] rcd_cnt [NUM_BANKS];
  logic [NUM_BANKS-1:0] rcd_done;

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
      wire hit = (cmd_bank == 3'(g));
      wire act_here = is_act && hit && !bank_open[g];
      wire pre_here = is_pre && (pre_all || hit);

      always_ff @(posedge clk) begin
        if (clr) begin
          bank_open[g] <= 1'b0;
          rcd_cnt[g] <= '0;
        end else if (act_here) begin
          bank_open[g] <= 1'b1;
          rcd_cnt[g] <= RCD_CYC;
        end else begin
          if (pre_here) begin
            bank_open[g] <= 1'b0;
          end
          if (rcd_cnt[g] != '0) begin
            rcd_cnt[g] <= rcd_cnt[g] - RCD_ONE;
          end
        end
      end

      // Counter loaded at the activate edge reaches 1 three cycles after the activate, the first cycle a column access is taken
      assign rcd_done[g] = bank_open[g] && (rcd_cnt[g] <= RCD_ONE);
    end
  endgenerate

  // Activate to an open bank is refused rather than reopening a row
  wire act_ok = is_act && !bank_open[cmd_bank];
  wire rdwr_ok = is_rdwr && rcd_done[cmd_bank];
  wire next_err = (is_act && bank_open[cmd_bank]) || (is_rdwr && !rdwr_ok);

  always_ff @(posedge clk) begin
    if (clr) begin
      act_valid <= 1'b0;
      act_info <= '0;
      rdwr_accept <= 1'b0;
      rdwr_reject <= 1'b0;
      rdwr_is_read <= 1'b0;
      rdwr_bank <= 3'h0;
      cmd_error <= 1'b0;
    end else begin
      act_valid <= act_ok;
      if (act_ok) begin
        act_info <= '{bank: cmd_bank, row: cmd_row};
      end
      rdwr_accept <= rdwr_ok;
      rdwr_reject <= is_rdwr && !rdwr_ok;
      if (is_rdwr) begin
        rdwr_is_read <= cr[`LPM_CA_READ_BIT];
        rdwr_bank <= cmd_bank;
      end
      cmd_error <= next_err;
    end
  end

endmodule

/* tb/lpm_host_model.sv */
// Host command bus model for the mode register and activate block
module lpm_host_model (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic req,
  input wire lpm_pkg::lpm_ca_t cmd,
  // Command bus
  output lpm_pkg::lpm_ca_t ca_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpm_pkg::*;
  logic tog = 1'b0;
  // Idle bus deselected and toggling so stale bits never read as a command
  always @(posedge clk) begin
    tog <= ~tog;
    ca_out <= req ? cmd : {1'b1, {20{tog}}};
    // Bench sequences stay in legal ranges and space activates widely
  end
endmodule

/* tb/lpm_mode_act_asserts.sv */
// Port checker for the mode register and activate block
`include "lpm_consts.svh"
module lpm_mode_act_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs
  input wire lpm_pkg::lpm_ca_t ca_in,
  input wire logic calib_ref_tied,
  // Outputs
  input wire logic mrr_valid,
  input wire logic [7:0] mrr_data,
  input wire logic calib_start,
  input wire logic [7:0] calib_code,
  input wire logic [7:0] refresh_bank_mask,
  input wire logic [7:0] refresh_segment_mask,
  input wire logic device_reset,
  input wire logic act_valid,
  input wire lpm_pkg::lpm_act_t act_info,
  input wire logic cmd_error
);
  import lpm_pkg::*;
  wire sel = !ca_in.cs_b;
  wire [7:0] ma = {ca_in.fall[1:0], ca_in.rise[9:4]};
  wire [7:0] op = ca_in.fall[9:2];
  wire wr = sel && ca_in.rise[3:0] == 4'h0;
  wire rd = sel && ca_in.rise[3:0] == 4'h8;
  wire act = sel && ca_in.rise[1:0] == 2'b10;
  wire [15:0] ai = {ca_in.rise[9:2], ca_in.fall[9:2]};
  wire op_ok = op == `LPM_CAL_INIT || op == `LPM_CAL_LONG ||
    op == `LPM_CAL_SHORT || op == `LPM_CAL_RESET;
  wire cc_ok = calib_code == `LPM_CAL_INIT || calib_code == `LPM_CAL_LONG ||
    calib_code == `LPM_CAL_SHORT || calib_code == `LPM_CAL_RESET;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_INFO: assert property (rd && ma == 8'h08 |-> ##3 mrr_valid &&
    mrr_data == 8'h50) else $error("device info read wrong");
  AST_CAL: assert property (wr && ma == 8'h0A && op_ok && !calib_ref_tied
    ##1 !calib_ref_tied [*3] |-> calib_start && calib_code == $past(op, 3))
    else $error("calibration not started");
  AST_CAL_RSVD: assert property (calib_start |-> cc_ok)
    else $error("reserved calibration code acted on");
  AST_CAL_TIED: assert property ((wr && ma == 8'h0A && calib_ref_tied)
    ##1 calib_ref_tied [*3] |-> !calib_start)
    else $error("calibration with strap high");
  AST_BMASK: assert property (wr && ma == 8'h10 |-> ##3
    refresh_bank_mask == $past(op, 3)) else $error("bank mask wrong");
  AST_SMASK: assert property (wr && ma == 8'h11 |-> ##3
    refresh_segment_mask == $past(op, 3)) else $error("segment mask wrong");
  AST_RST: assert property (wr && ma == 8'h3F |-> ##3 device_reset)
    else $error("reset write missed");
  AST_ACT: assert property (act |-> ##3 cmd_error || act_valid &&
    act_info == $past(ai, 3)) else $error("activate report wrong");
  cover property (calib_start);
  cover property (act_valid);
  cover property (cmd_error);
endmodule
bind lpm_mode_act lpm_mode_act_asserts u_chk (.clk(clk), .rst_b(rst_b),
  .ca_in(ca_in), .calib_ref_tied(calib_ref_tied), .mrr_valid(mrr_valid),
  .mrr_data(mrr_data), .calib_start(calib_start), .calib_code(calib_code),
  .refresh_bank_mask(refresh_bank_mask), .device_reset(device_reset),
  .refresh_segment_mask(refresh_segment_mask), .act_valid(act_valid),
  .act_info(act_info), .cmd_error(cmd_error));

/* tb/tb_top.sv */
// Command-level bench for the mode register and activate block
`include "lpm_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpm_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, tied = 1'b0;
  lpm_ca_t cmd = '0, ca;
  logic mv, cs, dr, av, ra, rj, rr, ce;
  logic [7:0] md, cc, bm, sm, bo, g_md;
  logic [2:0] rb;
  logic [6:0] g;
  lpm_act_t ai;
  int miscompares = 0, tests_run = 0;
  logic [7:0] codes [4] = '{`LPM_CAL_INIT, `LPM_CAL_LONG, `LPM_CAL_SHORT,
    `LPM_CAL_RESET};
  logic [7:0] rsvd [3] = '{8'h09, 8'h0B, 8'h0F};
  always #4 clk = ~clk;
  lpm_host_model host (.clk(clk), .req(req), .cmd(cmd), .ca_out(ca));
  lpm_mode_act DUT (.clk(clk), .rst_b(rst_b), .ca_in(ca),
    .calib_ref_tied(tied), .mrr_valid(mv), .mrr_data(md), .calib_start(cs),
    .calib_code(cc), .refresh_bank_mask(bm), .refresh_segment_mask(sm),
    .device_reset(dr), .act_valid(av), .act_info(ai), .bank_open(bo),
    .rdwr_accept(ra), .rdwr_reject(rj), .rdwr_is_read(rr), .rdwr_bank(rb),
    .cmd_error(ce));
  function automatic lpm_ca_t mr(logic r, logic [7:0] a, logic [7:0] o);
    return '{1'b0, {a[5:0], r, 3'h0}, {o, a[7:6]}};
  endfunction
  function automatic lpm_ca_t act(logic [2:0] b, logic [12:0] r);
    return '{1'b0, {b, r[12:8], 2'b10}, {r[7:0], 2'b00}};
  endfunction
  function automatic lpm_ca_t rw(logic r, logic [2:0] b);
    return '{1'b0, {b, 4'h0, r, 2'b01}, 10'h000};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task send(input lpm_ca_t c);
    @(posedge clk);
    req <= 1'b1;
    cmd <= c;
  endtask
  // Pulses are gathered over a window longer than the three-cycle answer
  task obs;
    @(posedge clk);
    req <= 1'b0;
    g = '0;
    g_md = '0;
    repeat (8) @(negedge clk) begin
      if (mv) g_md = md;
      g = g | {mv, cs, dr, av, ra, rj, ce};
    end
  endtask
  task report_and_stop;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("masks", {bm, sm}, {`LPM_BANK_MASK_RST, `LPM_SEG_MASK_RST});
    send(mr(1'b1, 8'h08, 8'h00));
    obs();
    chk("info", {g[6], g_md}, {1'b1, `LPM_INFO_WIDTH, `LPM_INFO_DENSITY,
      `LPM_INFO_TYPE});
    foreach (rsvd[i]) begin
      send(mr(1'b1, rsvd[i], 8'h00));
      obs();
      chk("rsvd_read", {g[6], g_md}, {1'b1, 8'h00});
    end
    foreach (codes[i]) begin
      send(mr(1'b0, 8'h0A, codes[i]));
      obs();
      chk("calib", {g[5], cc}, {1'b1, codes[i]});
    end
    send(mr(1'b0, 8'h0A, 8'h00));
    obs();
    chk("calib_rsvd", {g[5], cc}, {1'b0, `LPM_CAL_RESET});
    @(posedge clk) tied <= 1'b1;
    send(mr(1'b0, 8'h0A, `LPM_CAL_LONG));
    obs();
    chk("calib_tied", {g[5], cc}, {1'b0, `LPM_CAL_RESET});
    @(posedge clk) tied <= 1'b0;
    send(mr(1'b0, 8'h10, 8'hA5));
    send(mr(1'b0, 8'h11, 8'h3C));
    send(mr(1'b0, 8'h09, 8'hFF));
    obs();
    chk("bank_mask", bm, 8'hA5);
    chk("seg_mask", sm, 8'h3C);
    send(act(3'h5, 13'h1ABC));
    send(rw(1'b1, 3'h5));
    obs();
    chk("act_early", {g[3], g[1], g[0]}, 3'h7);
    chk("act_info", {ai, bo}, {3'h5, 13'h1ABC, 8'h20});
    send(rw(1'b1, 3'h5));
    obs();
    chk("read_ok", {g[2], g[1], rr, rb}, {3'h5, 3'h5});
    send(act(3'h5, 13'h0123));
    obs();
    chk("act_open", {g[3], g[0], ai}, {2'b01, 3'h5, 13'h1ABC});
    send('{1'b0, {3'h5, 3'h0, 4'hB}, 10'h000});
    obs();
    chk("precharge", bo, 8'h00);
    send(act(3'h5, 13'h0123));
    obs();
    chk("act_again", {g[3], ai}, {1'b1, 3'h5, 13'h0123});
    send(rw(1'b0, 3'h2));
    obs();
    chk("closed_bank", {g[2], g[1], rr}, 3'h2);
    send(mr(1'b0, 8'h3F, 8'h5A));
    obs();
    chk("reset", {g[4], bm, sm, bo}, {1'b1, 24'h00_0000});
    send(mr(1'b1, 8'h3F, 8'h00));
    obs();
    chk("reset_read", g[6], 1'b0);
    report_and_stop();
  end
endmodule
